// *** bench/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench
	import psrc_pkg::*;
;
	logic        ref_clk, resetn, psel, penable, pwrite, pready, pslverr, er;
	logic        wdog, sync_serial_zero_reset_bit, serial_port_one_reset_bit, serial_port_zero_reset_bit;
	logic [4:0]  port_rst;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, m1, m2, m4, rd;
	int          num_errors = 0;
	int          checks_done = 0;
	int          cycles = 0;
	psrc_top dut (.REF_CLK(ref_clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
		.PSLVERR(pslverr), .CAP_MASK_ONE(m1), .CAP_MASK_TWO(m2), .CAP_MASK_FOUR(m4),
		.WDOG_RST(wdog), .SYNC_SERIAL_ZERO_RESET_BIT_RST(sync_serial_zero_reset_bit), .SERIAL_PORT_ONE_RESET_BIT_RST(serial_port_one_reset_bit), .SERIAL_PORT_ZERO_RESET_BIT_RST(serial_port_zero_reset_bit),
		.PORT_RST(port_rst));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic print_verdict;
		if (num_errors == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors++;
			print_verdict();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp);
		apb(1'b1, a, d);
		chk("write error", 32'h0, {31'h0, er});
		apb(1'b0, a, 32'h0);
		chk("read data", exp, rd);
	endtask
	task automatic chk_outs(input logic [31:0] w, input logic [31:0] s, input logic [31:0] p);
		@(posedge ref_clk);
		chk("reset holds", {23'h0, w[3], s[4], s[1], s[0], p[4:0]},
			{23'h0, wdog, sync_serial_zero_reset_bit, serial_port_one_reset_bit, serial_port_zero_reset_bit, port_rst});
	endtask
	task automatic reset_values;
		apb(1'b0, PSRC_WDOG_OFF, 32'h0);
		chk("watchdog after reset", 32'h0, rd);
		apb(1'b0, PSRC_SERIAL_OFF, 32'h0);
		chk("serial after reset", 32'h0, rd);
		apb(1'b0, PSRC_PORT_OFF, 32'h0);
		chk("port after reset", 32'h0, rd);
		chk_outs(32'h0, 32'h0, 32'h0);
	endtask
	task automatic set_all;
		wr_rd(PSRC_WDOG_OFF, 32'hffffffff, 32'h00000008);
		wr_rd(PSRC_SERIAL_OFF, 32'hffffffff, 32'h00000013);
		wr_rd(PSRC_PORT_OFF, 32'hffffffff, 32'h0000001f);
		chk_outs(32'h8, 32'h13, 32'h1f);
	endtask
	task automatic masked_clear;
		{m1, m2, m4} <= {32'h0, 32'h2, 32'h4};
		wr_rd(PSRC_WDOG_OFF, 32'h0, 32'h00000008);
		wr_rd(PSRC_SERIAL_OFF, 32'h0, 32'h00000011);
		wr_rd(PSRC_PORT_OFF, 32'h0, 32'h0000001b);
		chk_outs(32'h8, 32'h11, 32'h1b);
	endtask
	task automatic release_and_unmapped;
		{m1, m2, m4} <= {3{32'hffffffff}};
		wr_rd(PSRC_WDOG_OFF, 32'h0, 32'h0);
		wr_rd(PSRC_SERIAL_OFF, 32'h0, 32'h0);
		wr_rd(PSRC_PORT_OFF, 32'h0, 32'h0);
		chk_outs(32'h0, 32'h0, 32'h0);
		apb(1'b1, 12'h04c, 32'hffffffff);
		chk("unmapped write error", 32'h1, {31'h0, er});
		apb(1'b0, 12'h04c, 32'h0);
		chk("unmapped read data", 32'h0, rd);
		chk_outs(32'h0, 32'h0, 32'h0);
	endtask
	initial begin
		{resetn, psel, penable, pwrite, paddr, pwdata} = 48'h0;
		{m1, m2, m4} = {3{32'hffffffff}};
		repeat (8) @(posedge ref_clk);
		resetn <= 1'b1;
		reset_values();
		set_all();
		masked_clear();
		release_and_unmapped();
		print_verdict();
	end
endmodule
`default_nettype wire

// *** design/psrc_mreg.sv ***
`timescale 1ns/100ps
`default_nettype none
module psrc_mreg
	import psrc_pkg::*;
(
	// Clock and reset.
	input  wire logic   clk,
	input  wire logic   rst_n,
	// Register port.
	psrc_reg_if.store   rp
);
	logic [31:0] q_q;
	logic [31:0] q_d;

	// Bits outside the mask keep their value, so absent units never change.
	always_comb begin
		q_d = q_q;
		if (rp.wr) begin
			q_d = (q_q & ~rp.mask) | (rp.wdata & rp.mask);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q_q <= PSRC_RESET_VAL;
		end else begin
			q_q <= q_d;
		end
	end

	assign rp.q = q_q;
endmodule
`default_nettype wire

// *** design/psrc_pkg.sv ***
package psrc_pkg;

	// Register byte offsets.
	localparam logic [11:0] PSRC_WDOG_OFF   = 12'h040;
	localparam logic [11:0] PSRC_SERIAL_OFF = 12'h044;
	localparam logic [11:0] PSRC_PORT_OFF   = 12'h048;

	// Field positions.
	localparam int PSRC_WDOG_BIT   = 3;
	localparam int PSRC_SYNC_SERIAL_ZERO_RESET_BIT_BIT   = 4;
	localparam int PSRC_SERIAL_PORT_ONE_RESET_BIT_BIT  = 1;
	localparam int PSRC_SERIAL_PORT_ZERO_RESET_BIT_BIT  = 0;
	localparam int PSRC_PORT_LSB   = 0;
	localparam int PSRC_PORT_COUNT = 5;

	// Implemented bits of each register; everything else is reserved.
	localparam logic [31:0] PSRC_WDOG_IMPL   = 32'h0000_0008;
	localparam logic [31:0] PSRC_SERIAL_IMPL = 32'h0000_0013;
	localparam logic [31:0] PSRC_PORT_IMPL   = 32'h0000_001f;

	localparam logic [31:0] PSRC_RESET_VAL = 32'h0000_0000;
	localparam logic [31:0] PSRC_ZERO      = 32'h0000_0000;

endpackage

// *** design/psrc_reg_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface psrc_reg_if;
	logic        wr;
	logic [31:0] wdata;
	logic [31:0] mask;
	logic [31:0] q;

	modport ctl (output wr, output wdata, output mask, input q);
	modport store (input wr, input wdata, input mask, output q);
endinterface
`default_nettype wire

// *** design/psrc_top.sv ***
// Notes on behaviour
// - Each write is masked by the matching capability input so only present units change.
// - The watchdog register holds a read/write reset bit at position 3.
// - The serial register holds bit 4 for sync serial 0, bit 1 for port 1, bit 0 for port 0.
// - The port register holds reset bits for ports A to E at bits 0 to 4.
// - Reserved bits read as zero and software keeps them during read-modify-write.
// - All reset control bits are cleared by reset.
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module psrc_top
	import psrc_pkg::*;
(
	// Clock and reset.
	input  wire logic                       REF_CLK,
	input  wire logic                       RESETN,
	// APB slave.
	input  wire logic                       PSEL,
	input  wire logic                       PENABLE,
	input  wire logic                       PWRITE,
	input  wire logic [11:0]                PADDR,
	input  wire logic [31:0]                PWDATA,
	output var  logic                       PREADY,
	output var  logic [31:0]                PRDATA,
	output var  logic                       PSLVERR,
	// Capability masks.
	input  wire logic [31:0]                CAP_MASK_ONE,
	input  wire logic [31:0]                CAP_MASK_TWO,
	input  wire logic [31:0]                CAP_MASK_FOUR,
	// Unit reset holds.
	output logic                            WDOG_RST,
	output logic                            SYNC_SERIAL_ZERO_RESET_BIT_RST,
	output logic                            SERIAL_PORT_ONE_RESET_BIT_RST,
	output logic                            SERIAL_PORT_ZERO_RESET_BIT_RST,
	output logic [PSRC_PORT_COUNT-1:0]      PORT_RST
);
	psrc_reg_if wd_if();
	psrc_reg_if se_if();
	psrc_reg_if po_if();

	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] prdata_q;
	logic        setup;
	logic        access;
	logic        hit_wd;
	logic        hit_se;
	logic        hit_po;
	logic [31:0] rd_mux;

	assign setup  = PSEL && !PENABLE;
	assign access = PSEL && PENABLE && pready_q;
	assign hit_wd = (PADDR == PSRC_WDOG_OFF);
	assign hit_se = (PADDR == PSRC_SERIAL_OFF);
	assign hit_po = (PADDR == PSRC_PORT_OFF);

	// Reserved positions never reach the store, so they read back as zero.
	assign wd_if.mask  = CAP_MASK_ONE & PSRC_WDOG_IMPL;
	assign se_if.mask  = CAP_MASK_TWO & PSRC_SERIAL_IMPL;
	assign po_if.mask  = CAP_MASK_FOUR & PSRC_PORT_IMPL;
	assign wd_if.wdata = PWDATA;
	assign se_if.wdata = PWDATA;
	assign po_if.wdata = PWDATA;
	assign wd_if.wr    = access && PWRITE && hit_wd;
	assign se_if.wr    = access && PWRITE && hit_se;
	assign po_if.wr    = access && PWRITE && hit_po;

	psrc_mreg u_wdog (.clk(REF_CLK), .rst_n(RESETN), .rp(wd_if.store));
	psrc_mreg u_serial (.clk(REF_CLK), .rst_n(RESETN), .rp(se_if.store));
	psrc_mreg u_port (.clk(REF_CLK), .rst_n(RESETN), .rp(po_if.store));

	always_comb begin
		rd_mux = PSRC_ZERO;
		if (hit_wd) begin
			rd_mux = wd_if.q & PSRC_WDOG_IMPL;
		end else if (hit_se) begin
			rd_mux = se_if.q & PSRC_SERIAL_IMPL;
		end else if (hit_po) begin
			rd_mux = po_if.q & PSRC_PORT_IMPL;
		end
	end

	// Ready is raised one edge after setup, giving a zero-wait access phase
	// while keeping every bus output on a flip-flop.
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= setup;
		end
	end

	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			prdata_q  <= PSRC_ZERO;
			pslverr_q <= 1'b0;
		end else if (setup) begin
			prdata_q  <= PWRITE ? PSRC_ZERO : rd_mux;
			pslverr_q <= !(hit_wd || hit_se || hit_po);
		end else if (access || !PSEL) begin
			// Clearing at the access edge keeps the answer to exactly one cycle.
			prdata_q  <= PSRC_ZERO;
			pslverr_q <= 1'b0;
		end
	end

	assign PREADY  = pready_q;
	assign PRDATA  = prdata_q;
	assign PSLVERR = pslverr_q;

	// Holds come straight from the stored bits.
	assign WDOG_RST  = wd_if.q[PSRC_WDOG_BIT];
	assign SYNC_SERIAL_ZERO_RESET_BIT_RST  = se_if.q[PSRC_SYNC_SERIAL_ZERO_RESET_BIT_BIT];
	assign SERIAL_PORT_ONE_RESET_BIT_RST = se_if.q[PSRC_SERIAL_PORT_ONE_RESET_BIT_BIT];
	assign SERIAL_PORT_ZERO_RESET_BIT_RST = se_if.q[PSRC_SERIAL_PORT_ZERO_RESET_BIT_BIT];
	assign PORT_RST  = po_if.q[PSRC_PORT_LSB +: PSRC_PORT_COUNT];

	sequence s_setup;
		PSEL && !PENABLE;
	endsequence

	sequence s_access;
		PSEL && PENABLE && PREADY;
	endsequence

	sequence s_wr_port;
		s_setup ##0 (PWRITE && hit_po) ##1 s_access;
	endsequence

	property p_mask_hold;
		@(posedge REF_CLK) disable iff (!RESETN)
		(wd_if.wr && !CAP_MASK_ONE[PSRC_WDOG_BIT]) |=> $stable(WDOG_RST);
	endproperty

	mask_write_a: assert property (p_mask_hold)
		else $error("masked watchdog bit changed");

	wdog_bit_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		wd_if.wr && CAP_MASK_ONE[PSRC_WDOG_BIT] |=> WDOG_RST == $past(PWDATA[PSRC_WDOG_BIT]))
		else $error("watchdog bit not written");

	serial_bits_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		se_if.wr && (CAP_MASK_TWO[4:0] == 5'h1f)
		|=> {SYNC_SERIAL_ZERO_RESET_BIT_RST, SERIAL_PORT_ONE_RESET_BIT_RST, SERIAL_PORT_ZERO_RESET_BIT_RST} ==
		{$past(PWDATA[PSRC_SYNC_SERIAL_ZERO_RESET_BIT_BIT]), $past(PWDATA[PSRC_SERIAL_PORT_ONE_RESET_BIT_BIT]),
		$past(PWDATA[PSRC_SERIAL_PORT_ZERO_RESET_BIT_BIT])})
		else $error("serial bits not written");

	port_bits_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		s_wr_port ##0 (CAP_MASK_FOUR[4:0] == 5'h1f)
		|=> PORT_RST == $past(PWDATA[PSRC_PORT_COUNT-1:0]))
		else $error("port bits not written");

	rsvd_zero_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		s_setup ##1 s_access |-> (PRDATA & ~(PSRC_WDOG_IMPL | PSRC_SERIAL_IMPL |
		PSRC_PORT_IMPL)) == PSRC_ZERO && !(hit_se && PRDATA[3:2] != 2'h0))
		else $error("reserved bits read nonzero");

	reset_clear_a: assert property (@(posedge REF_CLK)
		$rose(RESETN) |-> PORT_RST == 5'h00 && !WDOG_RST && !SYNC_SERIAL_ZERO_RESET_BIT_RST && !SERIAL_PORT_ONE_RESET_BIT_RST && !SERIAL_PORT_ZERO_RESET_BIT_RST)
		else $error("reset bits not cleared");

	hold_reset_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		!po_if.wr |=> $stable(PORT_RST))
		else $error("port reset hold changed without write");

	answer_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		s_setup |=> PREADY ##1 !PREADY)
		else $error("bus answer not one cycle after setup");

	sequence s_rd_wd;
		s_setup ##0 (hit_wd && !PWRITE) ##1 s_access;
	endsequence

	sequence s_rd_se;
		s_setup ##0 (hit_se && !PWRITE) ##1 s_access;
	endsequence

	sequence s_rd_po;
		s_setup ##0 (hit_po && !PWRITE) ##1 s_access;
	endsequence

	sequence s_wr_any;
		s_setup ##0 PWRITE ##1 s_access;
	endsequence

	// A masked write must leave the stored bit alone, not clear it.
	serial_mask_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		se_if.wr && !CAP_MASK_TWO[PSRC_SYNC_SERIAL_ZERO_RESET_BIT_BIT] |=> $stable(SYNC_SERIAL_ZERO_RESET_BIT_RST))
		else $error("masked serial bit changed");

	port_mask_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		po_if.wr |=> ((PORT_RST ^ $past(PORT_RST)) &
		~$past(CAP_MASK_FOUR[PSRC_PORT_COUNT-1:0])) == 5'h00)
		else $error("masked port bit changed");

	wdog_read_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		s_rd_wd |-> PRDATA[PSRC_WDOG_BIT] == WDOG_RST &&
		(PRDATA & ~PSRC_WDOG_IMPL) == PSRC_ZERO)
		else $error("watchdog read data wrong");

	serial_read_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		s_rd_se |-> {PRDATA[PSRC_SYNC_SERIAL_ZERO_RESET_BIT_BIT], PRDATA[PSRC_SERIAL_PORT_ONE_RESET_BIT_BIT],
		PRDATA[PSRC_SERIAL_PORT_ZERO_RESET_BIT_BIT]} == {SYNC_SERIAL_ZERO_RESET_BIT_RST, SERIAL_PORT_ONE_RESET_BIT_RST, SERIAL_PORT_ZERO_RESET_BIT_RST} &&
		(PRDATA & ~PSRC_SERIAL_IMPL) == PSRC_ZERO)
		else $error("serial read data wrong");

	port_read_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		s_rd_po |-> PRDATA[PSRC_PORT_LSB +: PSRC_PORT_COUNT] == PORT_RST &&
		(PRDATA & ~PSRC_PORT_IMPL) == PSRC_ZERO)
		else $error("port read data wrong");

	wdog_hold_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		!wd_if.wr |=> $stable(WDOG_RST))
		else $error("watchdog hold changed without write");

	serial_hold_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		!se_if.wr |=> $stable({SYNC_SERIAL_ZERO_RESET_BIT_RST, SERIAL_PORT_ONE_RESET_BIT_RST, SERIAL_PORT_ZERO_RESET_BIT_RST}))
		else $error("serial holds changed without write");

	write_data_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		s_wr_any |-> PRDATA == PSRC_ZERO)
		else $error("write answer carries data");

	// Outside the answer cycle the bus outputs rest at zero.
	answer_idle_a: assert property (@(posedge REF_CLK) disable iff (!RESETN)
		!PREADY |-> PRDATA == PSRC_ZERO && !PSLVERR)
		else $error("bus outputs not idle outside answer");
endmodule
`default_nettype wire
